// ---- common/ass_map.vh ----
// Register map, field positions, reset values and timing counts.
`ifndef ASS_MAP_VH
`define ASS_MAP_VH
// Register addresses on the plain register port.
`define ASS_ADDR_CTRL0     4'h0
`define ASS_ADDR_CTRL1     4'h1
`define ASS_ADDR_CTRL2     4'h2
`define ASS_ADDR_CTRL3     4'h3
`define ASS_ADDR_STATUS    4'h4
`define ASS_ADDR_RES0      4'h8
// Control 0 fields.
`define ASS_C0_START       0
`define ASS_C0_TRIG_MODE   1
`define ASS_C0_MODE_LO     2
`define ASS_C0_MODE_HI     3
// Control 1 fields.
`define ASS_C1_SCAN_LO     0
`define ASS_C1_SCAN_HI     1
`define ASS_C1_RES10       2
// Control 2 and 3 fields.
`define ASS_C2_SMP         0
`define ASS_C3_DMA         0
// Mode encodings.
`define ASS_MODE_SINGLE    2'h0
`define ASS_MODE_REP0      2'h1
`define ASS_MODE_REP1      2'h2
// Per-pin conversion times in converter clocks.
`define ASS_CYC_SMP8       6'h1c
`define ASS_CYC_SMP10      6'h21
`define ASS_CYC_NOSMP8     6'h2f
`define ASS_CYC_NOSMP10    6'h3a
// Misc widths and constants.
`define ASS_PIN_LAST       3'h7
`define ASS_ZERO16         16'h0000
`define ASS_DEFAULT_DATA   16'h0000
`endif

// ---- rtl/ass_result_mem.v ----
// Eight-word result memory with registered read data.
`timescale 1ns/1ps
module ass_result_mem (
  // Clock and reset.
  input  wire        clock,
  input  wire        arst_n,
  // Write side.
  input  wire        wr_en,
  input  wire [2:0]  wr_addr,
  input  wire [9:0]  wr_data,
  // Read side.
  input  wire [2:0]  rd_addr,
  output reg  [9:0]  rd_data
);

  // Storage for the eight per-pin results.
  reg [9:0] mem_r [0:7];
  integer   i;

  // Write port and registered read port; reset clears every word.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_r[i] <= 10'h000;
      end
      rd_data <= 10'h000;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // ass_result_mem

// ---- rtl/ass_sequencer.v ----
// Sweep sequencer of the A/D converter with its register port.
//
// Summary of operation
// - Single sweep converts each group pin once.
// - Scan group picks 2, 4, 6, 8 pins.
// - Single sweep without DMA: one end interrupt.
// - DMA on: interrupt after every pin.
// - Single sweep ends, clears start unless in trigger mode; software stops.
// - Start by write, or trigger edge after.
// - Repeat sweep 0 loops group without pause.
// - Repeat sweep 0 runs until start cleared.
// - Repeat modes without DMA raise no interrupt.
// - Repeat sweep 1 interleaves priority pins.
// - Scan group picks 1 to 4 priority pins.
// - Repeat sweep 1 ignores triggers while converting.
// - Repeat sweep 1 runs until start cleared.
// - No DMA: result goes to pin's register.
// - DMA on: every result into register zero.
// - Ten-bit mode fills bits nine to zero.
// - Eight-bit mode fills bits seven to zero.
// - Sample-hold takes 28 or 33 cycles.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ass_map.vh"
module ass_sequencer #(
  // Per-pin conversion cycles without sample-and-hold.
  parameter [5:0] CYC_NOSMP8  = `ASS_CYC_NOSMP8,
  parameter [5:0] CYC_NOSMP10 = `ASS_CYC_NOSMP10
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        arst_n,
  // Register port.
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Trigger inputs.
  input  wire        external_trigger_pin,
  input  wire        motor_timer_trigger,
  // Analog core interface.
  input  wire [9:0]  conv_code,
  output reg  [2:0]  conv_channel,
  output reg         conv_busy,
  // Interrupt request and DMA request pulse.
  output reg         conv_irq,
  output reg         dma_request
);

  // Control state held by software.
  reg        conversion_start_bit_r; // Start bit.
  reg        trigger_mode_select_r;  // Wait for hardware trigger.
  reg [1:0]  mode_r;                 // Sweep mode.
  reg        scan_group_lo_r;        // Scan group, low bit.
  reg        scan_group_hi_r;        // Scan group, high bit.
  reg        res10_r;                // Ten-bit resolution.
  reg        sample_hold_enable_r;   // Sample-and-hold on.
  reg        dma_mode_enable_r;      // DMA mode on.
  // Sequencer state.
  reg        running_r;              // A pass is converting.
  reg [5:0]  cyc_cnt_r;              // Cycles left for this pin.
  reg [2:0]  pin_r;                  // Pin being converted.
  reg [2:0]  next_normal_r;          // Next non-priority pin in sweep 1.
  reg [1:0]  prio_idx_r;             // Priority pin index in sweep 1.
  reg        prio_turn_r;            // Sweep 1: next slot is priority.
  // Synchronised trigger inputs and edge history.
  reg        ext_s1_r;
  reg        ext_s2_r;
  reg        ext_d_r;
  reg        tmr_s1_r;
  reg        tmr_s2_r;
  reg        tmr_d_r;
  // Result memory port.
  reg        mem_wr;
  reg [2:0]  mem_waddr;
  wire [9:0] mem_rdata;
  reg [2:0]  rd_pin_r;               // Memory read address latched.
  reg        rd_mem_r;               // Read answer comes from memory.
  reg [15:0] rd_reg_r;               // Read answer from a plain register.
  wire [1:0] scan_group;
  wire       trig_edge;
  wire       start_write;
  wire       stop_write;
  wire       pin_done;
  wire [9:0] result;

  // Last pin of the single or repeat-0 group for a scan code.
  function [2:0] group_last;
    input [1:0] code;
    begin
      case (code)
        2'h0:    group_last = 3'h1;
        2'h1:    group_last = 3'h3;
        2'h2:    group_last = 3'h5;
        default: group_last = 3'h7;
      endcase
    end
  endfunction

  // Last priority pin in repeat sweep 1 for a scan code.
  function [1:0] prio_last;
    input [1:0] code;
    begin
      prio_last = code;
    end
  endfunction

  // Conversion cycle count for the current settings.
  function [5:0] pin_cycles;
    input sample_hold_enable;
    input r10;
    begin
      if (sample_hold_enable) begin
        pin_cycles = r10 ? `ASS_CYC_SMP10 : `ASS_CYC_SMP8;
      end else begin
        pin_cycles = r10 ? CYC_NOSMP10 : CYC_NOSMP8;
      end
    end
  endfunction

  assign scan_group  = {scan_group_hi_r, scan_group_lo_r};
  assign start_write = reg_wr && (reg_addr == `ASS_ADDR_CTRL0) &&
                       reg_wdata[`ASS_C0_START];
  assign stop_write  = reg_wr && (reg_addr == `ASS_ADDR_CTRL0) &&
                       !reg_wdata[`ASS_C0_START];
  // Falling edge of the external pin or rising edge of the timer event.
  assign trig_edge   = (ext_d_r && !ext_s2_r) || (tmr_s2_r && !tmr_d_r);
  assign pin_done    = running_r && (cyc_cnt_r == 6'h01);
  assign result      = res10_r ? conv_code : {2'h0, conv_code[9:2]};

  // Trigger synchronisers; the second stage and its delayed copy feed edge logic.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_d_r  <= 1'b1;
      tmr_s1_r <= 1'b0;
      tmr_s2_r <= 1'b0;
      tmr_d_r  <= 1'b0;
    end else begin
      ext_s1_r <= external_trigger_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
      tmr_s1_r <= motor_timer_trigger;
      tmr_s2_r <= tmr_s1_r;
      tmr_d_r  <= tmr_s2_r;
    end
  end

  // Configuration registers written by software.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trigger_mode_select_r <= 1'b0;
      mode_r                <= `ASS_MODE_SINGLE;
      scan_group_lo_r       <= 1'b0;
      scan_group_hi_r       <= 1'b0;
      res10_r               <= 1'b0;
      sample_hold_enable_r  <= 1'b0;
      dma_mode_enable_r     <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ASS_ADDR_CTRL0: begin
          trigger_mode_select_r <= reg_wdata[`ASS_C0_TRIG_MODE];
          mode_r <= reg_wdata[`ASS_C0_MODE_HI:`ASS_C0_MODE_LO];
        end
        `ASS_ADDR_CTRL1: begin
          scan_group_lo_r <= reg_wdata[`ASS_C1_SCAN_LO];
          scan_group_hi_r <= reg_wdata[`ASS_C1_SCAN_HI];
          res10_r         <= reg_wdata[`ASS_C1_RES10];
        end
        `ASS_ADDR_CTRL2: begin
          sample_hold_enable_r <= reg_wdata[`ASS_C2_SMP];
        end
        `ASS_ADDR_CTRL3: begin
          dma_mode_enable_r <= reg_wdata[`ASS_C3_DMA];
        end
        default: begin
          dma_mode_enable_r <= dma_mode_enable_r;
        end
      endcase
    end
  end

  // Sweep sequencer: start, pin stepping, stop and events.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conversion_start_bit_r <= 1'b0;
      running_r     <= 1'b0;
      cyc_cnt_r     <= 6'h00;
      pin_r         <= 3'h0;
      next_normal_r <= 3'h0;
      prio_idx_r    <= 2'h0;
      prio_turn_r   <= 1'b0;
      mem_wr        <= 1'b0;
      mem_waddr     <= 3'h0;
      conv_irq      <= 1'b0;
      dma_request   <= 1'b0;
      conv_channel  <= 3'h0;
      conv_busy     <= 1'b0;
    end else begin
      mem_wr      <= 1'b0;
      conv_irq    <= 1'b0;
      dma_request <= 1'b0;
      if (stop_write) begin
        conversion_start_bit_r <= 1'b0;
        running_r <= 1'b0;
      end else if (start_write && !running_r &&
                   !reg_wdata[`ASS_C0_TRIG_MODE]) begin
        // The trigger mode written with the start bit decides, since the
        // stored copy only changes at this same edge.
        // software start
        conversion_start_bit_r <= 1'b1;
        running_r   <= 1'b1;
        pin_r       <= 3'h0;
        prio_idx_r  <= 2'h0;
        prio_turn_r <= 1'b0;
        next_normal_r <= {1'b0, prio_last(scan_group)} + 3'h1;
        cyc_cnt_r   <= pin_cycles(sample_hold_enable_r, res10_r);
      end else if (start_write) begin
        // Armed; a trigger edge will begin the pass.
        conversion_start_bit_r <= 1'b1;
      end else if (conversion_start_bit_r && trigger_mode_select_r &&
                   trig_edge &&
                   !(running_r && mode_r == `ASS_MODE_REP1)) begin
        running_r   <= 1'b1;
        pin_r       <= 3'h0;
        prio_idx_r  <= 2'h0;
        prio_turn_r <= 1'b0;
        next_normal_r <= {1'b0, prio_last(scan_group)} + 3'h1;
        cyc_cnt_r   <= pin_cycles(sample_hold_enable_r, res10_r);
      end else if (pin_done) begin
        mem_wr    <= 1'b1;
        mem_waddr <= dma_mode_enable_r ? 3'h0 : pin_r;
        if (dma_mode_enable_r) begin
          conv_irq    <= 1'b1;
          dma_request <= 1'b1;
        end
        cyc_cnt_r <= pin_cycles(sample_hold_enable_r, res10_r);
        case (mode_r)
          `ASS_MODE_SINGLE: begin
            if (pin_r == group_last(scan_group)) begin
              running_r <= 1'b0;
              if (!trigger_mode_select_r) begin
                conversion_start_bit_r <= 1'b0;
              end
              if (!dma_mode_enable_r) begin
                conv_irq <= 1'b1;
              end
            end else begin
              pin_r <= pin_r + 3'h1;
            end
          end
          `ASS_MODE_REP0: begin
            if (pin_r == group_last(scan_group)) begin
              pin_r <= 3'h0;
            end else begin
              pin_r <= pin_r + 3'h1;
            end
          end
          `ASS_MODE_REP1: begin
            if (prio_turn_r) begin
              pin_r       <= {1'b0, prio_idx_r};
              prio_turn_r <= 1'b0;
            end else if (pin_r > {1'b0, prio_last(scan_group)} ||
                         prio_idx_r == prio_last(scan_group)) begin
              // Priority group done; convert one normal pin next.
              prio_idx_r  <= 2'h0;
              pin_r       <= next_normal_r;
              prio_turn_r <= 1'b1;
              if (next_normal_r == `ASS_PIN_LAST) begin
                next_normal_r <= {1'b0, prio_last(scan_group)} + 3'h1;
              end else begin
                next_normal_r <= next_normal_r + 3'h1;
              end
            end else begin
              prio_idx_r <= prio_idx_r + 2'h1;
              pin_r      <= {1'b0, prio_idx_r} + 3'h1;
            end
          end
          default: begin
            running_r <= 1'b0;
          end
        endcase
      end else if (running_r) begin
        cyc_cnt_r <= cyc_cnt_r - 6'h01;
      end
      conv_channel <= pin_r;
      conv_busy    <= running_r;
    end
  end

  // Read decode: register and memory both answer in the next cycle.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_pin_r <= 3'h0;
      rd_mem_r <= 1'b0;
      rd_reg_r <= `ASS_ZERO16;
    end else begin
      rd_pin_r <= reg_addr[2:0];
      rd_mem_r <= reg_rd && reg_addr[3];
      rd_reg_r <= `ASS_ZERO16;
      if (reg_rd) begin
        case (reg_addr)
          `ASS_ADDR_CTRL0:
            rd_reg_r <= {12'h000, mode_r, trigger_mode_select_r,
                         conversion_start_bit_r};
          `ASS_ADDR_CTRL1:
            rd_reg_r <= {13'h0000, res10_r, scan_group_hi_r,
                         scan_group_lo_r};
          `ASS_ADDR_CTRL2:
            rd_reg_r <= {15'h0000, sample_hold_enable_r};
          `ASS_ADDR_CTRL3:
            rd_reg_r <= {15'h0000, dma_mode_enable_r};
          `ASS_ADDR_STATUS:
            rd_reg_r <= {12'h000, pin_r, running_r};
          default:
            rd_reg_r <= `ASS_DEFAULT_DATA;
        endcase
      end
    end
  end

  // Read data mux; memory words come from the memory's registered read port.
  always @* begin
    reg_rdata = rd_mem_r ? {6'h00, mem_rdata} : rd_reg_r;
  end

  // Result memory; its read address follows the bus address directly.
  ass_result_mem u_mem (
    .clock   (clock),
    .arst_n  (arst_n),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (result),
    .rd_addr (reg_addr[2:0]),
    .rd_data (mem_rdata)
  );

endmodule // ass_sequencer

// ---- testbench/adc_sweep_sequencer_bench.sv ----
// Self-checking bench for the sweep sequencer.
`timescale 1ns/1ps
module adc_sweep_sequencer_bench;
  // Shortened plain conversion times keep the run brief.
  localparam [5:0] NS8 = 6'h14;
  localparam [5:0] NS10 = 6'h19;
  reg         clock = 1'b0;
  reg         arst_n, reg_wr, reg_rd, ext_pin, motor_trig, res, sample_hold_enable;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata, d;
  wire [15:0] reg_rdata;
  wire [9:0]  conv_code;
  wire [2:0]  conv_channel;
  wire        conv_busy, conv_irq, dma_request;
  integer n_fail = 0, tests_run = 0, n_irq = 0, n_dma = 0;
  integer seed = 10, r, i, s, np, cyc, t;
  always #5 clock = ~clock;
  ass_sequencer #(.CYC_NOSMP8(NS8), .CYC_NOSMP10(NS10)) dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_trigger_pin(ext_pin),
    .motor_timer_trigger(motor_trig), .conv_code(conv_code),
    .conv_channel(conv_channel), .conv_busy(conv_busy),
    .conv_irq(conv_irq), .dma_request(dma_request));
  ass_core_model core (.clock(clock), .conv_channel(conv_channel),
    .conv_busy(conv_busy), .conv_code(conv_code));
  // Pulses are counted as they stand, one cycle each.
  always @(posedge clock) begin
    if (conv_irq === 1'b1) n_irq <= n_irq + 1;
    if (dma_request === 1'b1) n_dma <= n_dma + 1;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run++;
      if (g !== e) begin
        $display("BAD %s expected %h seen %h", nm, e, g);
        n_fail++;
      end
    end
  endtask
  // Bus cycles end one step past the edge so outputs have settled.
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clock);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, output [15:0] v);
    begin
      @(posedge clock);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task cfg(input [1:0] sc, input rs, input sm, input dm);
    begin
      wr(4'h1, {13'h0000, rs, sc}); wr(4'h2, {15'h0000, sm});
      wr(4'h3, {15'h0000, dm});
      core.log_q.delete(); n_irq = 0; n_dma = 0;
    end
  endtask
  task wait_idle(output integer c);
    begin
      c = 0;
      // Busy rises one edge after the start write is taken.
      repeat (2) @(posedge clock);
      #1;
      while (conv_busy !== 1'b0 && c < 3000) begin
        @(posedge clock);
        #1 c = c + 1;
      end
      if (c >= 3000) begin n_fail++; end_sim; end
    end
  endtask
  task idle(input integer n);
    begin repeat (n) @(posedge clock); #1; end
  endtask
  function integer pin_cyc(input rs, input sm);
    pin_cyc = sm ? (rs ? 33 : 28) : (rs ? NS10 : NS8);
  endfunction
  function [15:0] exp_res(input [2:0] ch, input rs);
    reg [9:0] c;
    begin
      c = {ch, 4'ha, ch};
      exp_res = rs ? {6'h00, c} : {8'h00, c[9:2]};
    end
  endfunction
  initial begin
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 16'h0000; ext_pin = 1'b1; motor_trig = 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    rd(4'h5, d); chk("unmapped", 16'h0000, d);
    // Single sweeps over every group, random resolution and sample-hold.
    for (s = 0; s < 4; s++) begin
      r = $random(seed); res = r[0]; sample_hold_enable = r[1]; np = 2 * s + 2;
      cfg(s, res, sample_hold_enable, 1'b0);
      wr(4'h0, 16'h0001);
      wait_idle(cyc);
      t = np * pin_cyc(res, sample_hold_enable);
      chk("sweep time", 1, cyc >= t - 1 && cyc <= t + 4);
      chk("irq count", 1, n_irq);
      rd(4'h0, d); chk("start bit", 16'h0000, d & 16'h0001);
      chk("pins", np, core.log_q.size());
      for (i = 0; i < core.log_q.size(); i++) chk("order", i, core.log_q[i]);
      for (i = 0; i < np; i++) begin
        rd(4'h8 + i, d); chk("result", exp_res(i, res), d);
      end
      if (np < 8) begin rd(4'h8 + np, d); chk("outside group", 0, d); end
    end
    // DMA sweep of four pins started by the motor timer trigger.
    cfg(2'h1, res, 1'b1, 1'b1);
    wr(4'h0, 16'h0003); idle(4);
    chk("wait trigger", 0, conv_busy);
    motor_trig <= 1'b1; idle(6);
    chk("triggered", 1, conv_busy);
    wait_idle(cyc); motor_trig <= 1'b0;
    chk("dma pulses", 4, n_dma);
    chk("dma irqs", 4, n_irq);
    // Read here only in the DMA controller's place, after the pass.
    rd(4'h8, d); chk("result zero", exp_res(3'h3, res), d);
    // Repeat sweep 0 over two pins until software stops it.
    cfg(2'h0, res, 1'b1, 1'b0);
    wr(4'h0, 16'h0005); idle(200);
    chk("still running", 1, conv_busy);
    chk("repeat irqs", 0, n_irq);
    for (i = 0; i < core.log_q.size(); i++) chk("loop order", i % 2, core.log_q[i]);
    wr(4'h0, 16'h0004); idle(3);
    chk("stopped", 0, conv_busy);
    // Repeat sweep 1 by external edge; a second edge mid-pin is ignored.
    cfg(2'h0, res, 1'b1, 1'b0);
    wr(4'h0, 16'h000b); idle(4);
    chk("edge wait", 0, conv_busy);
    ext_pin <= 1'b0; idle(6);
    chk("edge start", 1, conv_busy);
    ext_pin <= 1'b1; idle(40);
    ext_pin <= 1'b0; idle(400);
    chk("enough pins", 1, core.log_q.size() >= 8);
    for (i = 0; i < core.log_q.size(); i++) chk("priority order", (i % 2 == 0) ? 0 : ((i - 1) / 2) % 7 + 1, core.log_q[i]);
    chk("rep1 irqs", 0, n_irq);
    wr(4'h0, 16'h000a); idle(3);
    chk("rep1 stopped", 0, conv_busy);
    end_sim;
  end
endmodule // adc_sweep_sequencer_bench

// ---- testbench/ass_core_model.sv ----
// Analog core model that answers the sequencer with one code per pin.
`timescale 1ns/1ps
module ass_core_model (
  // Clock.
  input  wire       clock,
  // Sequencer side.
  input  wire [2:0] conv_channel,
  input  wire       conv_busy,
  output wire [9:0] conv_code
);
  logic [2:0] log_q [$];  // Pins in the order they were started.
  reg   [2:0] last_r;     // Channel seen in the previous cycle.
  reg         busy_r;     // Busy seen in the previous cycle.
  reg         tog_r = 1'b0; // Idle pattern, flips every cycle.
  // Each pin has a fixed code that names it; while idle the code toggles
  // so that a sample taken out of a pass can never match by accident.
  assign conv_code = conv_busy ? {conv_channel, 4'ha, conv_channel}
                               : {10{tog_r}};
  // A pin is logged when a pass opens or when the channel moves on.
  always @(posedge clock) begin
    tog_r  <= ~tog_r;
    busy_r <= conv_busy;
    last_r <= conv_channel;
    if (conv_busy && (!busy_r || conv_channel != last_r)) begin
      log_q.push_back(conv_channel);
    end
  end
endmodule // ass_core_model

// ---- testbench/ass_seq_checker.sv ----
// Port checker for the sweep sequencer, bound to every instance.
`timescale 1ns/1ps
`include "ass_map.vh"
module ass_seq_checker #(
  parameter [5:0] CYC_NOSMP8  = `ASS_CYC_NOSMP8,
  parameter [5:0] CYC_NOSMP10 = `ASS_CYC_NOSMP10
) (
  // Clock and reset.
  input wire        clock,
  input wire        arst_n,
  // Register port.
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Triggers and core.
  input wire        external_trigger_pin,
  input wire        motor_timer_trigger,
  input wire [9:0]  conv_code,
  input wire [2:0]  conv_channel,
  input wire        conv_busy,
  input wire        conv_irq,
  input wire        dma_request
);
  reg [1:0] mode_r;  // Mode last written.
  reg       res_r;   // Ten-bit resolution last written.
  reg       smp_r;   // Sample-and-hold last written.
  reg       dma_r;   // DMA mode last written.
  reg [6:0] gap_r;   // Cycles since the last result pulse.
  reg       valid_r; // Busy has held since that pulse.
  wire      wr0 = reg_wr && reg_addr == `ASS_ADDR_CTRL0;
  wire [6:0] n_pin = {1'b0, smp_r ? (res_r ? `ASS_CYC_SMP10 : `ASS_CYC_SMP8)
                                  : (res_r ? CYC_NOSMP10 : CYC_NOSMP8)};
  // Shadow of the configuration; the gap is only judged inside one pass.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_r  <= 2'h0;
      res_r   <= 1'b0;
      smp_r   <= 1'b0;
      dma_r   <= 1'b0;
      gap_r   <= 7'h00;
      valid_r <= 1'b0;
    end else begin
      if (wr0) mode_r <= reg_wdata[3:2];
      if (reg_wr && reg_addr == `ASS_ADDR_CTRL1) res_r <= reg_wdata[2];
      if (reg_wr && reg_addr == `ASS_ADDR_CTRL2) smp_r <= reg_wdata[0];
      if (reg_wr && reg_addr == `ASS_ADDR_CTRL3) dma_r <= reg_wdata[0];
      gap_r   <= dma_request ? 7'h01 : gap_r + 7'h01;
      valid_r <= conv_busy & (dma_request | valid_r);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  irq_per_pin_a: assert property (dma_r && dma_request |-> ##[0:1] conv_irq)
    else $error("result pulse without interrupt");
  repeat_quiet_a: assert property (!dma_r && mode_r != `ASS_MODE_SINGLE |-> !conv_irq)
    else $error("interrupt in repeat mode");
  dma_off_quiet_a: assert property (!dma_r |-> !dma_request)
    else $error("result pulse with DMA off");
  start_runs_a: assert property (wr0 && reg_wdata[0] && !reg_wdata[1] && !conv_busy |-> ##2 conv_busy)
    else $error("start write did not start");
  trig_waits_a: assert property (wr0 && reg_wdata[1] && !conv_busy |=> !conv_busy)
    else $error("trigger mode started without edge");
  stop_halts_a: assert property (wr0 && !reg_wdata[0] |-> ##[1:2] !conv_busy)
    else $error("start clear did not stop");
  sweep_end_a: assert property (mode_r == `ASS_MODE_SINGLE && !dma_r && conv_irq |-> ##[0:2] !conv_busy)
    else $error("sweep interrupt before end");
  pin_time_a: assert property (dma_request && valid_r |-> gap_r == n_pin)
    else $error("pin conversion time wrong");
  narrow_result_a: assert property (reg_rd && reg_addr[3] && !res_r |=> reg_rdata[15:8] == 8'h00)
    else $error("eight-bit result too wide");
  wide_result_a: assert property (reg_rd && reg_addr[3] && res_r |=> reg_rdata[15:10] == 6'h00)
    else $error("ten-bit result too wide");
endmodule // ass_seq_checker
bind ass_sequencer ass_seq_checker #(
  .CYC_NOSMP8(CYC_NOSMP8), .CYC_NOSMP10(CYC_NOSMP10)
) chk_i (
  .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .external_trigger_pin(external_trigger_pin),
  .motor_timer_trigger(motor_timer_trigger), .conv_code(conv_code),
  .conv_channel(conv_channel), .conv_busy(conv_busy),
  .conv_irq(conv_irq), .dma_request(dma_request)
);
